// *** src/ecio_port.sv ***
// Purpose: external control port: edge-triggered commands, polarity-set status pins
// Assumes: AHB-Lite slave, zero wait states, single-word transfers
// Notes:   commands are one-cycle pulses; status pins are registered
`include "ecio_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ecio_port #(
    parameter int IN_W = `ECIO_NUM_IN   // number of edge inputs
) (
    input  wire logic                   core_clk_i,   // core clock, 50 MHz
    input  wire logic                   rst_n_i,      // async reset, active low
    // AHB-Lite slave
    input  wire logic                   hsel_i,
    input  wire logic [7:0]             haddr_i,
    input  wire logic [1:0]             htrans_i,
    input  wire logic                   hwrite_i,
    input  wire logic [2:0]             hsize_i,
    input  wire logic [31:0]            hwdata_i,
    input  wire logic                   hready_i,
    output logic      [31:0]            hrdata_o,
    output logic                        hreadyout_o,
    output logic                        hresp_o,
    // device core
    input  wire ecio_pkg::ecio_status_type status_i,    // live device state
    input  wire logic                   remote_i,     // remote interface active
    input  wire ecio_pkg::ecio_func_type func_i,      // active function
    input  wire logic                   trig_req_i,   // trigger event pulse
    output ecio_pkg::ecio_cmd_type      cmd_o,        // command pulses
    // connector inputs (low-active edges, memory select levels)
    input  wire logic                   out_off_n_i,
    input  wire logic                   out_on_n_i,
    input  wire logic                   seq_start_n_i,
    input  wire logic                   seq_stop_n_i,
    input  wire logic                   seq_hold_n_i,
    input  wire logic                   seq_br1_n_i,
    input  wire logic                   seq_br2_n_i,
    input  wire logic                   recall_n_i,
    input  wire logic                   mem_sel1_i,
    input  wire logic                   mem_sel2_i,
    input  wire logic                   peak_clr_n_i,
    // connector outputs
    output logic                        power_o,
    output logic                        output_state_o,
    output logic                        prot_o,
    output logic                        limit_o,
    output logic                        auto_gain_cal_state_o,
    output logic                        busy_o,
    output logic                        range_o,
    output logic                        step_sync0_o,
    output logic                        step_sync1_o,
    output logic                        trigger_o
);

    // ----
    // register storage
    // ----
    logic [2:0]      ctrl_reg;        // enable, status polarity, trigger polarity
    logic [30:0]     trig_width_reg;  // trigger width in cycles
    logic [IN_W-1:0] event_reg;       // sticky accepted-edge flags
    logic [1:0]      last_mem_reg;    // memory of last recall
    logic [30:0]     trig_cnt_reg;    // trigger pulse down-counter
    ecio_pkg::ecio_cmd_type cmd_reg;  // command pulses

    // ----
    // input synchronisers
    // ----
    logic [IN_W-1:0] pins_n;    // raw edge inputs
    logic [IN_W-1:0] levels;    // synchronised levels
    logic [IN_W-1:0] falls;     // falling-edge pulses
    logic [1:0]      sel_level; // synchronised memory select

    assign pins_n = {peak_clr_n_i, recall_n_i, seq_br2_n_i, seq_br1_n_i,
                     seq_hold_n_i, seq_stop_n_i, seq_start_n_i, out_on_n_i,
                     out_off_n_i};

    // one edge detector per control input
    genvar gi;
    generate
        for (gi = 0; gi < IN_W; gi++) begin : g_in
            ecio_edge_in u_edge (
                .core_clk_i (core_clk_i),
                .rst_n_i    (rst_n_i),
                .pin_i      (pins_n[gi]),
                .level_o    (levels[gi]),
                .fall_o     (falls[gi])
            );
        end
        // memory select levels, synchronised the same way
        for (gi = 0; gi < 2; gi++) begin : g_sel
            ecio_edge_in u_sel (
                .core_clk_i (core_clk_i),
                .rst_n_i    (rst_n_i),
                .pin_i      (gi == 0 ? mem_sel1_i : mem_sel2_i),
                .level_o    (sel_level[gi]),
                .fall_o     ()
            );
        end
    endgenerate

    // ----
    // acceptance gate
    // ----
    logic            accept;   // inputs honoured now
    logic [IN_W-1:0] taken;    // accepted edges

    assign accept = ctrl_reg[`ECIO_CTRL_EN_BIT] & ~remote_i;
    assign taken  = accept ? falls : '0;

    // ----
    // command pulses
    // ----
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_reg <= '0;
        end else begin
            cmd_reg.output_off  <= taken[`ECIO_EV_OFF];
            cmd_reg.output_on   <= taken[`ECIO_EV_ON];
            cmd_reg.seq_start   <= taken[`ECIO_EV_START];
            cmd_reg.seq_stop    <= taken[`ECIO_EV_STOP];
            cmd_reg.seq_hold    <= taken[`ECIO_EV_HOLD];
            cmd_reg.seq_branch1 <= taken[`ECIO_EV_BR1];
            cmd_reg.seq_branch2 <= taken[`ECIO_EV_BR2];
            cmd_reg.recall      <= taken[`ECIO_EV_RECALL];
            // compile only for sequence and simulation memories
            cmd_reg.compile     <= taken[`ECIO_EV_RECALL] &
                                   (func_i != ecio_pkg::ECIO_FUNC_CONT);
            cmd_reg.peak_clear  <= taken[`ECIO_EV_PKCLR];
            // selector captured with the recall edge
            if (taken[`ECIO_EV_RECALL]) begin
                cmd_reg.mem_sel <= {sel_level[1], sel_level[0]};
            end
        end
    end

    assign cmd_o = cmd_reg;

    // last recalled memory number, readable by software
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_mem_reg <= 2'h0;
        end else if (taken[`ECIO_EV_RECALL]) begin
            last_mem_reg <= {sel_level[1], sel_level[0]};
        end
    end

    // ----
    // AHB-Lite address phase capture
    // ----
    logic       wr_pend_reg;  // write data phase pending
    logic [7:0] wr_addr_reg;  // captured write address
    logic       rd_go;        // read address phase accepted
    logic       wr_go;        // write address phase accepted

    assign rd_go = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
    assign wr_go = hsel_i & hready_i & htrans_i[1] & hwrite_i;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= wr_go;
            if (wr_go) begin
                wr_addr_reg <= haddr_i;
            end
        end
    end

    // write strobes for the data phase
    logic wr_ctrl;
    logic wr_trig;
    logic wr_event;
    assign wr_ctrl  = wr_pend_reg & (wr_addr_reg == `ECIO_CTRL_OFS);
    assign wr_trig  = wr_pend_reg & (wr_addr_reg == `ECIO_TRIG_OFS);
    assign wr_event = wr_pend_reg & (wr_addr_reg == `ECIO_EVENT_OFS);

    // ----
    // writable settings
    // ----
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= 3'(`ECIO_CTRL_RST);
        end else if (wr_ctrl) begin
            ctrl_reg <= hwdata_i[2:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trig_width_reg <= 31'(`ECIO_TRIG_RST);
        end else if (wr_trig) begin
            trig_width_reg <= hwdata_i[30:0];
        end
    end

    // sticky edge flags: set wins over write-one-to-clear
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            event_reg <= '0;
        end else begin
            event_reg <= (event_reg & ~(wr_event ? hwdata_i[IN_W-1:0] : '0)) | taken;
        end
    end

    // ----
    // trigger pulse, started by the core or by software
    // ----
    logic trig_start;
    assign trig_start = trig_req_i | (wr_trig & hwdata_i[`ECIO_TRIG_GO_BIT]);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trig_cnt_reg <= '0;
        end else if (trig_start) begin
            // software start takes the width written with it
            trig_cnt_reg <= wr_trig ? hwdata_i[30:0] : trig_width_reg;
        end else if (trig_cnt_reg != '0) begin
            trig_cnt_reg <= trig_cnt_reg - 31'h1;
        end
    end

    // ----
    // status pins
    // ----
    // maps an active-high state to its pin level: positive keeps it
    function automatic logic pol_map(input logic state, input logic positive);
        pol_map = positive ? state : ~state;
    endfunction

    logic pos;   // status polarity: 1 positive
    assign pos = ctrl_reg[`ECIO_CTRL_POL_BIT];

    // registered pins, driven regardless of the enable
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            power_o               <= 1'b0;
            output_state_o        <= 1'b1;
            prot_o                <= 1'b1;
            limit_o               <= 1'b1;
            auto_gain_cal_state_o <= 1'b1;
            busy_o                <= 1'b1;
            range_o               <= 1'b0;
            step_sync0_o          <= 1'b0;
            step_sync1_o          <= 1'b0;
            trigger_o             <= 1'b0;
        end else begin
            power_o               <= status_i.power_on;
            output_state_o        <= pol_map(status_i.output_on, pos);
            prot_o                <= pol_map(status_i.prot_active, pos);
            limit_o               <= pol_map(status_i.limit_active, pos);
            auto_gain_cal_state_o <= pol_map(status_i.auto_gain_cal_state, pos);
            busy_o                <= pol_map(status_i.busy, pos);
            range_o               <= status_i.range_100v;
            step_sync0_o          <= status_i.step_sync[0];
            step_sync1_o          <= status_i.step_sync[1];
            trigger_o             <= pol_map(trig_start | (trig_cnt_reg > 31'h1),
                                             ctrl_reg[`ECIO_CTRL_TPOL_BIT]);
        end
    end

    // ----
    // read data
    // ----
    logic [31:0] rd_next;
    always_comb begin
        rd_next = 32'h0000_0000;
        case (haddr_i)
            `ECIO_CTRL_OFS:  rd_next = {29'h0, ctrl_reg};
            `ECIO_TRIG_OFS:  rd_next = {1'b0, trig_width_reg};
            `ECIO_STATE_OFS: rd_next = {22'h0, status_i.step_sync, remote_i,
                                        status_i.range_100v, status_i.busy,
                                        status_i.auto_gain_cal_state,
                                        status_i.limit_active, status_i.prot_active,
                                        status_i.output_on, status_i.power_on};
            `ECIO_EVENT_OFS: rd_next = {18'h0, last_mem_reg, 3'h0, event_reg};
            `ECIO_PINS_OFS:  rd_next = {21'h0, sel_level, levels};
            default:         rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (rd_go) begin
            hrdata_o <= rd_next;
        end
    end

    assign hreadyout_o = 1'b1;   // zero wait states
    assign hresp_o     = 1'b0;   // always OKAY

endmodule

`default_nettype wire

// *** src/ecio_params.svh ***
// Purpose: constants for the external control port
// Assumes: 50 MHz core clock, AHB-Lite register access, one word per register
// Notes:   definitions only
//
// Summary of operation
// - port enable gates inputs; status always driven
// - remote operation blocks all control inputs
// - memory select: input1 bit0, input2 bit1
// - recall edge loads memory, compiles sequence/simulation
// - falling edges switch output off or on
// - sequence edges start, stop, hold, branch
// - peak-clear falling edge clears peak hold
// - polarity setting covers five status outputs
// - output and auto-gain state follow polarity
// - protection and limiter active follow polarity
// - busy low under negative, reversed positive
// - range output low 200 V, high 100 V
// - step sync code on two outputs
// - trigger pulse polarity is configurable
// - trigger pulse width is configurable
// - power output high while powered on
`ifndef ECIO_PARAMS_SVH
`define ECIO_PARAMS_SVH

// ----
// register byte offsets
// ----
`define ECIO_CTRL_OFS     8'h00
`define ECIO_TRIG_OFS     8'h04
`define ECIO_STATE_OFS    8'h08
`define ECIO_EVENT_OFS    8'h0C
`define ECIO_PINS_OFS     8'h10

// ----
// control register fields
// ----
`define ECIO_CTRL_EN_BIT    0
`define ECIO_CTRL_POL_BIT   1
`define ECIO_CTRL_TPOL_BIT  2
`define ECIO_CTRL_RST       32'h0000_0000

// ----
// trigger width (cycles) and status bits
// ----
`define ECIO_TRIG_RST       32'h0007_A120
`define ECIO_TRIG_GO_BIT    31
`define ECIO_ST_POWER       0
`define ECIO_ST_OUTPUT      1
`define ECIO_ST_PROT        2
`define ECIO_ST_LIMIT       3
`define ECIO_ST_AGC         4
`define ECIO_ST_BUSY        5
`define ECIO_ST_R100        6
`define ECIO_ST_REMOTE      7
`define ECIO_ST_SYNC_LSB    8

// ----
// event bits (sticky, write one to clear)
// ----
`define ECIO_EV_OFF         0
`define ECIO_EV_ON          1
`define ECIO_EV_START       2
`define ECIO_EV_STOP        3
`define ECIO_EV_HOLD        4
`define ECIO_EV_BR1         5
`define ECIO_EV_BR2         6
`define ECIO_EV_RECALL      7
`define ECIO_EV_PKCLR       8
`define ECIO_EV_MEM_LSB     12
`define ECIO_NUM_IN         9

// ----
// AHB constants
// ----
`define ECIO_HTRANS_NSEQ    2'h2

`endif

// *** src/ecio_pkg.sv ***
// Purpose: types for the external control port
// Assumes: constants come from ecio_params.svh
// Notes:   status and command groups travel as packed structs
package ecio_pkg;

    // device state presented on the status pins
    typedef struct packed {
        logic       power_on;        // unit powered
        logic       output_on;       // output enabled
        logic       prot_active;     // protection tripped
        logic       limit_active;    // limiter engaged
        logic       auto_gain_cal_state; // auto-gain/cal on
        logic       busy;            // software busy
        logic       range_100v;      // 100 V range selected
        logic [1:0] step_sync;       // step sync code
    } ecio_status_type;

    // one-cycle commands to the device core
    typedef struct packed {
        logic       output_off;
        logic       output_on;
        logic       seq_start;
        logic       seq_stop;
        logic       seq_hold;
        logic       seq_branch1;
        logic       seq_branch2;
        logic       recall;          // load selected memory
        logic       compile;         // compile after recall
        logic       peak_clear;
        logic [1:0] mem_sel;         // memory 1..4 as 0..3
    } ecio_cmd_type;

    // active function, decides compile on recall
    typedef enum logic [1:0] {
        ECIO_FUNC_CONT,
        ECIO_FUNC_SEQ,
        ECIO_FUNC_SIM
    } ecio_func_type;

endpackage

// *** src/ecio_edge_in.sv ***
// Purpose: synchronise one control input and flag its falling edge
// Assumes: input is a level from a logic or contact source
// Notes:   two flops then an edge stage; first flop read only by the second
`timescale 1ns/1ps
`default_nettype none

module ecio_edge_in (
    input  wire logic core_clk_i,   // core clock
    input  wire logic rst_n_i,      // async reset, active low
    input  wire logic pin_i,        // raw input level
    output logic      level_o,      // synchronised level
    output logic      fall_o        // one-cycle falling-edge pulse
);

    logic meta_reg;   // first synchroniser stage
    logic sync_reg;   // second stage
    logic last_reg;   // previous synchronised level

    // idle high so no edge fires at reset release
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            last_reg <= 1'b1;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level_o = sync_reg;
    assign fall_o  = last_reg & ~sync_reg;

endmodule

`default_nettype wire

// *** bench/ecio_ctrl_model.sv ***
// Purpose: outside controller closing contacts on the control inputs
// Assumes: an open contact reads high through its pull-up
// Notes:   each request keeps its contact closed for eight cycles
`timescale 1ns/1ps
`default_nettype none
module ecio_ctrl_model (
    input  wire logic       core_clk_i, // core clock
    input  wire logic       rst_n_i,    // async reset, active low
    input  wire logic [8:0] fire_i,     // close request per contact
    output logic      [8:0] pins_n_o    // contact levels, low closed
);
    logic [3:0] hold_reg [9]; // closed-time counters
    // ----
    // contact timing
    // ----
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        for (int i = 0; i < 9; i++) begin
            if (!rst_n_i) begin
                hold_reg[i] <= 4'h0;
                pins_n_o[i] <= 1'b1;
            end else begin
                if (fire_i[i]) hold_reg[i] <= 4'h8;
                else if (hold_reg[i] != 4'h0) hold_reg[i] <= hold_reg[i] - 4'h1;
                pins_n_o[i] <= !(fire_i[i] || hold_reg[i] > 4'h1);
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/ecio_port_assertions.sv ***
// Purpose: timing checks on the control port pins
// Assumes: one clock, async low reset
// Notes:   status polarity is inferred from the five pins together
`timescale 1ns/1ps
`default_nettype none
module ecio_port_assertions (
    input wire logic                      core_clk_i,
    input wire logic                      rst_n_i,
    input wire ecio_pkg::ecio_status_type status_i,
    input wire logic                      remote_i,
    input wire ecio_pkg::ecio_func_type   func_i,
    input wire ecio_pkg::ecio_cmd_type    cmd_o,
    input wire logic                      out_on_n_i,
    input wire logic                      mem_sel1_i,
    input wire logic                      mem_sel2_i,
    input wire logic                      power_o,
    input wire logic                      output_state_o,
    input wire logic                      prot_o,
    input wire logic                      limit_o,
    input wire logic                      auto_gain_cal_state_o,
    input wire logic                      busy_o,
    input wire logic                      range_o,
    input wire logic                      step_sync0_o,
    input wire logic                      step_sync1_o
);
    // ----
    // pin relations
    // ----
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    power_map_a: assert property ($past(rst_n_i) |-> power_o == $past(status_i.power_on))
        else $error("power pin off its state");
    range_sync_a: assert property ($past(rst_n_i) |->
        {range_o, step_sync1_o, step_sync0_o} == $past(status_i[2:0])) else $error("range or sync pin");
    pol_shared_a: assert property ($past(rst_n_i) |->
        ({output_state_o, prot_o, limit_o, auto_gain_cal_state_o, busy_o} ^ $past(status_i[7:3]))
        inside {5'h00, 5'h1F}) else $error("status pins disagree on polarity");
    single_pulse_a: assert property (cmd_o.output_off |=> !cmd_o.output_off)
        else $error("off command longer than a cycle");
    pulse_cause_a: assert property (cmd_o.output_on |->
        !$past(out_on_n_i, 2) && !$past(out_on_n_i, 3)) else $error("on command without low pin");
    remote_block_a: assert property (remote_i [*6] |-> cmd_o[11:2] == 10'h000)
        else $error("command while remote");
    compile_recall_a: assert property (cmd_o.recall || cmd_o.compile |->
        cmd_o.recall && cmd_o.compile == ($past(func_i) != ecio_pkg::ECIO_FUNC_CONT))
        else $error("compile wrong for recall");
    mem_select_a: assert property (cmd_o.recall |->
        cmd_o.mem_sel == {$past(mem_sel2_i, 3), $past(mem_sel1_i, 3)}) else $error("memory select");
    cover property (cmd_o.recall && cmd_o.compile);
    cover property (remote_i [*6]);
    cover property (cmd_o.output_off && cmd_o.peak_clear);
endmodule
bind ecio_port ecio_port_assertions chk (.core_clk_i, .rst_n_i, .status_i, .remote_i, .func_i,
    .cmd_o, .out_on_n_i, .mem_sel1_i, .mem_sel2_i, .power_o, .output_state_o, .prot_o, .limit_o,
    .auto_gain_cal_state_o, .busy_o, .range_o, .step_sync0_o, .step_sync1_o);
`default_nettype wire

// *** bench/external_control_io_tb.sv ***
// Purpose: bench for the external control port
// Assumes: zero-wait bus, one slave, contacts from the controller model
// Notes:   pin cases are table rows; reset, blocking and trigger by hand
`include "ecio_params.svh"
`timescale 1ns/1ps
`default_nettype none
module external_control_io_tb;
    typedef struct packed {
        logic [8:0] pins; // contacts to close
        logic [1:0] mem;  // memory select
        logic [1:0] func; // active function
        logic [9:0] exp;  // expected pulses, off down to peak clear
    } ecio_row_type;
    logic                      core_clk_i  = 1'b0;
    logic                      rst_n_i     = 1'b0;
    logic                      hsel_i      = 1'b0;
    logic [7:0]                haddr_i     = 8'h00;
    logic [1:0]                htrans_i    = 2'h0;
    logic                      hwrite_i    = 1'b0;
    logic [2:0]                hsize_i     = 3'h2;
    logic [31:0]               hwdata_i    = 32'h0;
    logic [31:0]               hrdata_o;
    logic                      hreadyout_o;
    logic                      hresp_o;
    ecio_pkg::ecio_status_type status_i    = '0;
    logic                      remote_i    = 1'b0;
    ecio_pkg::ecio_func_type   func_i      = ecio_pkg::ECIO_FUNC_CONT;
    logic                      trig_req_i  = 1'b0;
    ecio_pkg::ecio_cmd_type    cmd_o;
    logic [8:0]                fire_req    = 9'h000;
    logic [8:0]                pins_n;
    logic [1:0]                mem_sel     = 2'h0;
    logic [9:0]                st_pins;    // power down to trigger
    int                        miscompares = 0;
    int                        num_checks  = 0;
    ecio_row_type rows [12] = '{'{9'h001, 2'h0, 2'h0, 10'h200}, '{9'h002, 2'h0, 2'h0, 10'h100},
        '{9'h004, 2'h0, 2'h0, 10'h080}, '{9'h008, 2'h0, 2'h0, 10'h040},
        '{9'h010, 2'h0, 2'h0, 10'h020}, '{9'h020, 2'h0, 2'h0, 10'h010},
        '{9'h040, 2'h0, 2'h0, 10'h008}, '{9'h080, 2'h0, 2'h0, 10'h004},
        '{9'h080, 2'h1, 2'h1, 10'h006}, '{9'h080, 2'h2, 2'h2, 10'h006},
        '{9'h080, 2'h3, 2'h1, 10'h006}, '{9'h101, 2'h0, 2'h0, 10'h201}};
    ecio_port dut (.core_clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
        .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .status_i,
        .remote_i, .func_i, .trig_req_i, .cmd_o, .out_off_n_i(pins_n[0]), .out_on_n_i(pins_n[1]),
        .seq_start_n_i(pins_n[2]), .seq_stop_n_i(pins_n[3]), .seq_hold_n_i(pins_n[4]),
        .seq_br1_n_i(pins_n[5]), .seq_br2_n_i(pins_n[6]), .recall_n_i(pins_n[7]),
        .mem_sel1_i(mem_sel[0]), .mem_sel2_i(mem_sel[1]), .peak_clr_n_i(pins_n[8]),
        .power_o(st_pins[9]), .output_state_o(st_pins[8]), .prot_o(st_pins[7]),
        .limit_o(st_pins[6]), .auto_gain_cal_state_o(st_pins[5]), .busy_o(st_pins[4]),
        .range_o(st_pins[3]), .step_sync1_o(st_pins[2]), .step_sync0_o(st_pins[1]),
        .trigger_o(st_pins[0]));
    ecio_ctrl_model ctl (.core_clk_i, .rst_n_i, .fire_i(fire_req), .pins_n_o(pins_n));
    // ----
    // clock and helpers
    // ----
    initial begin
        forever #10 core_clk_i = ~core_clk_i;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one single transfer, waits on ready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge core_clk_i);
        hsel_i <= 1'b1;
        htrans_i <= `ECIO_HTRANS_NSEQ;
        haddr_i <= a;
        hwrite_i <= wr;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask
    // close contacts, gather pulses
    task automatic fire(input logic [8:0] m, output logic [9:0] acc, output int n,
                        output logic [1:0] mem);
        acc = 10'h000;
        n = 0;
        mem = 2'h0;
        @(posedge core_clk_i) fire_req <= m;
        @(posedge core_clk_i) fire_req <= 9'h000;
        repeat (14) begin
            @(posedge core_clk_i);
            #1;
            if (cmd_o[11:2] !== 10'h000) n++;
            acc = acc | cmd_o[11:2];
            if (cmd_o.recall === 1'b1) mem = cmd_o.mem_sel;
        end
    endtask
    // count cycles at the active trigger level
    task automatic trig_count(input logic act, output int n);
        n = 0;
        repeat (20) begin
            #1;
            if (st_pins[0] === act) n++;
            @(posedge core_clk_i) trig_req_i <= 1'b0;
        end
    endtask
    // ----
    // test sequence
    // ----
    initial begin
        logic [31:0] rd;
        logic [9:0]  acc;
        int          n;
        logic [1:0]  mem;
        repeat (3) @(posedge core_clk_i);
        #1;
        check("reset pins", st_pins, 10'h1F0);
        repeat (3) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        bus(1'b0, `ECIO_TRIG_OFS, 32'h0, rd);
        check("width reset", rd, `ECIO_TRIG_RST);
        bus(1'b0, 8'h20, 32'h0, rd);
        check("unmapped read", rd, 32'h0);
        check("bus response", hresp_o, 32'h0);
        bus(1'b1, `ECIO_CTRL_OFS, 32'h1, rd);
        foreach (rows[i]) begin
            @(posedge core_clk_i);
            mem_sel <= rows[i].mem;
            func_i <= ecio_pkg::ecio_func_type'(rows[i].func);
            fire(rows[i].pins, acc, n, mem);
            check("row pulses", acc, rows[i].exp);
            check("row single", n, 32'h1);
            if (rows[i].pins[7]) check("row memory", mem, rows[i].mem);
        end
        $display("row tests done");
        bus(1'b0, `ECIO_EVENT_OFS, 32'h0, rd);
        check("events", rd, 32'h31FF);
        bus(1'b1, `ECIO_EVENT_OFS, 32'h1FF, rd);
        @(posedge core_clk_i) remote_i <= 1'b1;
        fire(9'h1FF, acc, n, mem);
        check("remote blocked", acc, 10'h000);
        @(posedge core_clk_i) remote_i <= 1'b0;
        bus(1'b1, `ECIO_CTRL_OFS, 32'h0, rd);
        fire(9'h1FF, acc, n, mem);
        check("disabled blocked", acc, 10'h000);
        bus(1'b0, `ECIO_EVENT_OFS, 32'h0, rd);
        check("no events", rd, 32'h3000);
        for (int p = 0; p < 2; p++) begin
            bus(1'b1, `ECIO_CTRL_OFS, 32'(p) << 1, rd);
            for (int q = 0; q < 4; q++) begin
                @(posedge core_clk_i) status_i <= {q[0], q[0] ? 5'h15 : 5'h0A, q[1], q[1:0]};
                repeat (3) @(posedge core_clk_i);
                #1;
                check("status pins", st_pins[9:1], {status_i[8],
                    p ? status_i[7:3] : ~status_i[7:3], status_i[2:0]});
            end
        end
        $display("status tests done");
        bus(1'b1, `ECIO_CTRL_OFS, 32'h1, rd);
        bus(1'b1, `ECIO_TRIG_OFS, 32'h8000_0004, rd);
        trig_count(1'b0, n);
        check("low trigger width", n, 32'h4);
        check("low trigger idle", st_pins[0], 32'h1);
        bus(1'b1, `ECIO_CTRL_OFS, 32'h5, rd);
        bus(1'b1, `ECIO_TRIG_OFS, 32'h3, rd);
        @(posedge core_clk_i) trig_req_i <= 1'b1;
        trig_count(1'b1, n);
        check("high trigger width", n, 32'h3);
        bus(1'b1, `ECIO_CTRL_OFS, 32'h0, rd);
        $display("trigger tests done");
        wrap_up();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge core_clk_i);
        miscompares++;
        wrap_up();
    end
endmodule
`default_nettype wire
